// ==== ddrm_pkg.sv ====
/*
 * Shared constants, types and the burst address function for the DDR2
 * memory device core: command codes, register selects, mode field
 * positions, reset values, DLL lock count and the carrier structs.
 * Assumes nothing beyond a SystemVerilog-2012 compiler.
 */
package ddrm_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int MODE_W = 15;
    localparam int COL_W  = 10;

    // ------------------------------------------------------------------
    // command codes, {ras_n, cas_n, we_n} with chip select low
    // ------------------------------------------------------------------
    localparam logic [2:0] CMD_LM   = 3'h0;
    localparam logic [2:0] CMD_REF  = 3'h1;
    localparam logic [2:0] CMD_PRE  = 3'h2;
    localparam logic [2:0] CMD_ACT  = 3'h3;
    localparam logic [2:0] CMD_WR   = 3'h4;
    localparam logic [2:0] CMD_RD   = 3'h5;
    localparam logic [2:0] CMD_NOP  = 3'h7;

    // ------------------------------------------------------------------
    // register selects on the bank bits, field positions, reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] SEL_MODE = 3'h0;
    localparam logic [2:0] SEL_EXT1 = 3'h1;
    localparam logic [2:0] SEL_EXT2 = 3'h2;
    localparam logic [2:0] SEL_EXT3 = 3'h3;
    localparam int MR_BL_LSB        = 0;
    localparam int MR_BL_MSB        = 2;
    localparam int MR_ORDER_BIT     = 3;
    localparam int MR_DLL_RST_BIT   = 8;
    localparam int EXT_DLL_OFF_BIT  = 0;
    localparam int ADDR_AP_BIT      = 10;
    localparam logic [2:0]  BL_EIGHT   = 3'h3;
    localparam logic [14:0] MODE_RESET = 15'h0000;
    localparam logic [14:0] EXT_RESET  = 15'h0000;

    // ------------------------------------------------------------------
    // timing: link clock cycles from dll reset to first access (200)
    // ------------------------------------------------------------------
    localparam logic [7:0] DLL_LOCK_CYCLES = 8'hC8;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_WRITE} ddrm_phase_t;

    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  ba;
        logic [13:0] addr;
    } ddrm_cmd_t;

    typedef struct packed {
        logic [1:0]        mask;
        logic [WORD_W-1:0] data;
    } ddrm_lane_t;

    typedef struct packed {
        ddrm_phase_t      phase;
        logic [1:0]       pair;
        logic [2:0]       bank;
        logic [COL_W-1:0] col;
        logic             bl8;
        logic             ilv;
        logic             ap;
    } ddrm_burst_t;

    // column low bits for beat idx of a burst starting at start
    function automatic logic [2:0] ddrm_burst_col(
        input logic [2:0] start,
        input logic [2:0] idx,
        input logic       ilv
    );
        logic [1:0] low;
        low = start[1:0] + idx[1:0];
        if (ilv) begin
            return start ^ idx;
        end
        return {start[2] ^ idx[2], low};
    endfunction : ddrm_burst_col

endpackage : ddrm_pkg

// ==== ddrm_core.sv ====
/*
 * DDR2 memory device core: command register on the link clock, mode and
 * extended register loading, DLL lock timing, burst ordering, 4-word
 * prefetch storage and double-rate data in and out, one 16-bit die slice.
 * Assumes the controller drives commands and write data on link_clk,
 * and that sys_clk only watches the ready status.
 */
`timescale 1ns/1ps

module ddrm_core #(
    parameter int ROW_KEEP = 2,
    parameter int COL_BITS = 5
) (
    input  logic                sys_clk,
    input  logic                rst_n,
    input  logic                link_clk,
    input  ddrm_pkg::ddrm_cmd_t cmd,
    input  logic [15:0]         dq_in,
    output logic [15:0]         dq_out,
    output logic                dq_oe,
    input  logic                lower_byte_write_mask,
    input  logic                upper_byte_write_mask,
    input  logic                lower_byte_strobe_in,
    output logic                lower_byte_strobe_out,
    output logic                lower_byte_strobe_oe,
    input  logic                upper_byte_strobe_in,
    output logic                upper_byte_strobe_out,
    output logic                upper_byte_strobe_oe,
    output logic                core_ready
);

    localparam int MEM_AW = 3 + ROW_KEEP + COL_BITS - 2;

    // ------------------------------------------------------------------
    // link-side reset
    // ------------------------------------------------------------------
    logic lrst_s1_q;
    logic lrst_s2_q;

    // rst_n lives on sys_clk, so it is resynchronised before use here
    always_ff @(posedge link_clk) begin
        lrst_s1_q <= rst_n;
        lrst_s2_q <= lrst_s1_q;
    end

    // ------------------------------------------------------------------
    // state declarations
    // ------------------------------------------------------------------
    logic [14:0]           mode_q, mode_d;
    logic [14:0]           ext_q [1:3];
    logic [14:0]           ext_d [1:3];
    logic [7:0]            dll_cnt_q, dll_cnt_d;
    logic                  dll_run_q, dll_run_d;
    logic [7:0]            open_q, open_d;
    logic [ROW_KEEP-1:0]   row_q [8];
    logic [ROW_KEEP-1:0]   row_d [8];
    ddrm_pkg::ddrm_burst_t bq, bd;
    logic [63:0]           rbuf_q, rbuf_d;
    logic [63:0]           wbuf_q, wbuf_d;
    logic [7:0]            wen_q, wen_d;
    logic [15:0]           hi_q, hi_d;
    logic [15:0]           lo_word_q, lo_word_d;
    logic                  oe_q, oe_d;
    logic                  ready_q, ready;
    logic [15:0]           lo_q;
    ddrm_pkg::ddrm_lane_t  cap_q;
    logic [63:0]           mem [2**MEM_AW];
    logic                  mem_we;
    logic [MEM_AW-1:0]     nib;
    logic [63:0]           wdat;
    logic [7:0]            wmsk;
    logic [2:0]            op;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    // deselect or low clock enable both read as no operation
    always_comb begin
        op = ddrm_pkg::CMD_NOP;
        if (cmd.cke && !cmd.cs_n) begin
            op = {cmd.ras_n, cmd.cas_n, cmd.we_n};
        end
    end

    // ------------------------------------------------------------------
    // next state of the link side
    // ------------------------------------------------------------------
    // one process covers registers, DLL timer, banks and the burst engine
    always_comb begin
        logic [2:0]  c0;
        logic [2:0]  c1;
        logic [63:0] word;
        logic        last;
        logic        accept;
        c0      = ddrm_pkg::ddrm_burst_col(bq.col[2:0], {bq.pair, 1'b0}, bq.ilv);
        c1      = ddrm_pkg::ddrm_burst_col(bq.col[2:0], {bq.pair, 1'b1}, bq.ilv);
        word    = '0;
        last    = bq.pair == (bq.bl8 ? 2'h3 : 2'h1);
        accept  = 1'b0;
        mode_d  = mode_q;
        ext_d   = ext_q;
        dll_cnt_d = dll_cnt_q;
        dll_run_d = dll_run_q;
        open_d  = open_q;
        row_d   = row_q;
        bd      = bq;
        rbuf_d  = rbuf_q;
        wbuf_d  = wbuf_q;
        wen_d   = wen_q;
        hi_d    = hi_q;
        lo_word_d = lo_word_q;
        oe_d    = 1'b0;
        mem_we  = 1'b0;
        wdat    = wbuf_q;
        wmsk    = wen_q;
        // block select from high column bits, half select from the order
        nib = {bq.bank, row_q[bq.bank], bq.col[COL_BITS-1:3], c0[2]};

        // lock counts down only after a dll reset; a disabled dll blocks
        ready = dll_run_q && (dll_cnt_q == 8'h00)
                && !ext_q[1][ddrm_pkg::EXT_DLL_OFF_BIT];
        if (dll_cnt_q != 8'h00) begin
            dll_cnt_d = dll_cnt_q - 8'h01;
        end

        // one pair of words per link cycle
        case (bq.phase)
            ddrm_pkg::PH_READ: begin
                // even pair fetches the whole nibble, odd pair reuses it
                word   = bq.pair[0] ? rbuf_q : mem[nib];
                rbuf_d = word;
                hi_d   = word[{c0[1:0], 4'h0} +: 16];
                lo_word_d = word[{c1[1:0], 4'h0} +: 16];
                oe_d   = 1'b1;
            end
            ddrm_pkg::PH_WRITE: begin
                wdat[{c0[1:0], 4'h0} +: 16] = cap_q.data;
                wdat[{c1[1:0], 4'h0} +: 16] = dq_in;
                wmsk[{c0[1:0], 1'b0} +: 2]  = ~cap_q.mask;
                wmsk[{c1[1:0], 1'b0} +: 2]  = ~{upper_byte_write_mask,
                                                lower_byte_write_mask};
                wbuf_d = wdat;
                wen_d  = bq.pair[0] ? 8'h00 : wmsk;
                mem_we = bq.pair[0];
            end
            default: begin
            end
        endcase

        if (bq.phase != ddrm_pkg::PH_IDLE) begin
            bd.pair = bq.pair + 2'h1;
            if (last) begin
                bd.phase = ddrm_pkg::PH_IDLE;
                if (bq.ap) begin
                    open_d[bq.bank] = 1'b0;
                end
            end
        end

        // new access only at a nibble edge: idle, burst end, or a cut
        accept = (bq.phase == ddrm_pkg::PH_IDLE)
                 || (bq.pair[0] && (last || (bq.bl8 &&
                     ((op == ddrm_pkg::CMD_RD) == (bq.phase == ddrm_pkg::PH_READ)))));

        case (op)
            ddrm_pkg::CMD_LM: begin
                // loads mid-burst are dropped rather than corrupting it
                if (bq.phase == ddrm_pkg::PH_IDLE && !cmd.ba[2]) begin
                    if (cmd.ba == ddrm_pkg::SEL_MODE) begin
                        mode_d = {1'b0, cmd.addr};
                        mode_d[ddrm_pkg::MR_DLL_RST_BIT] = 1'b0;
                        if (cmd.addr[ddrm_pkg::MR_DLL_RST_BIT]) begin
                            dll_cnt_d = ddrm_pkg::DLL_LOCK_CYCLES - 8'h01;
                            dll_run_d = 1'b1;
                        end
                    end else begin
                        ext_d[cmd.ba[1:0]] = {1'b0, cmd.addr};
                    end
                end
            end
            ddrm_pkg::CMD_ACT: begin
                open_d[cmd.ba] = 1'b1;
                row_d[cmd.ba]  = cmd.addr[ROW_KEEP-1:0];
            end
            ddrm_pkg::CMD_PRE: begin
                if (cmd.addr[ddrm_pkg::ADDR_AP_BIT]) begin
                    open_d = 8'h00;
                end else begin
                    open_d[cmd.ba] = 1'b0;
                end
            end
            ddrm_pkg::CMD_RD, ddrm_pkg::CMD_WR: begin
                if (accept && ready && open_q[cmd.ba]) begin
                    bd.phase = (op == ddrm_pkg::CMD_RD) ? ddrm_pkg::PH_READ
                                                        : ddrm_pkg::PH_WRITE;
                    bd.pair  = 2'h0;
                    bd.bank  = cmd.ba;
                    bd.col   = cmd.addr[ddrm_pkg::COL_W-1:0];
                    bd.bl8   = mode_q[ddrm_pkg::MR_BL_MSB:ddrm_pkg::MR_BL_LSB]
                               == ddrm_pkg::BL_EIGHT;
                    bd.ilv   = mode_q[ddrm_pkg::MR_ORDER_BIT];
                    bd.ap    = cmd.addr[ddrm_pkg::ADDR_AP_BIT];
                    wen_d    = 8'h00;
                end
            end
            default: begin
            end
        endcase
    end

    // ------------------------------------------------------------------
    // link-side registers
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (!lrst_s2_q) begin
            mode_q    <= ddrm_pkg::MODE_RESET;
            ext_q     <= '{default: ddrm_pkg::EXT_RESET};
            dll_cnt_q <= 8'h00;
            dll_run_q <= 1'b0;
            open_q    <= 8'h00;
            row_q     <= '{default: '0};
            bq        <= '0;
            rbuf_q    <= '0;
            wbuf_q    <= '0;
            wen_q     <= 8'h00;
            hi_q      <= 16'h0000;
            lo_word_q <= 16'h0000;
            oe_q      <= 1'b0;
            ready_q   <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            ext_q     <= ext_d;
            dll_cnt_q <= dll_cnt_d;
            dll_run_q <= dll_run_d;
            open_q    <= open_d;
            row_q     <= row_d;
            bq        <= bd;
            rbuf_q    <= rbuf_d;
            wbuf_q    <= wbuf_d;
            wen_q     <= wen_d;
            hi_q      <= hi_d;
            lo_word_q <= lo_word_d;
            oe_q      <= oe_d;
            ready_q   <= ready;
        end
    end

    // ------------------------------------------------------------------
    // nibble storage, one merged write per completed nibble
    // ------------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        for (int b = 0; b < 8; b++) begin
            if (mem_we && wmsk[b]) begin
                mem[nib][b*8 +: 8] <= wdat[b*8 +: 8];
            end
        end
    end

    // ------------------------------------------------------------------
    // falling-edge half: second read word out, first write word in
    // ------------------------------------------------------------------
    always_ff @(negedge link_clk) begin
        if (!lrst_s2_q) begin
            lo_q  <= 16'h0000;
            cap_q <= '0;
        end else begin
            lo_q  <= lo_word_q;
            cap_q <= '{mask: {upper_byte_write_mask, lower_byte_write_mask},
                       data: dq_in};
        end
    end

    // ------------------------------------------------------------------
    // pins: data and strobes follow the clock halves
    // ------------------------------------------------------------------
    // the half-cycle mux is the price of double rate without a 2x clock
    assign dq_out                = link_clk ? hi_q : lo_q;
    assign dq_oe                 = oe_q;
    assign lower_byte_strobe_out = link_clk & oe_q;
    assign lower_byte_strobe_oe  = oe_q;
    assign upper_byte_strobe_out = link_clk & oe_q;
    assign upper_byte_strobe_oe  = oe_q;

    // ------------------------------------------------------------------
    // ready status into the system clock domain
    // ------------------------------------------------------------------
    logic rdy_s1_q;
    logic rdy_s2_q;
    logic core_ready_q;

    // level crossing; only the third stage, core_ready_q, is looked at
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdy_s1_q     <= 1'b0;
            rdy_s2_q     <= 1'b0;
            core_ready_q <= 1'b0;
        end else begin
            rdy_s1_q     <= ready_q;
            rdy_s2_q     <= rdy_s1_q;
            core_ready_q <= rdy_s2_q;
        end
    end

    assign core_ready = core_ready_q;

endmodule : ddrm_core

// ==== ddrm_core_assertions.sv ====
/*
 * Port checker for the memory core: read start timing, burst spans,
 * strobe shape, refusal before the dll has locked.
 * Assumes it is bound onto ddrm_core and sees only its ports.
 */
`timescale 1ns/1ps

module ddrm_core_assertions (
    input logic                sys_clk,
    input logic                rst_n,
    input logic                link_clk,
    input ddrm_pkg::ddrm_cmd_t cmd,
    input logic                dq_oe,
    input logic                lower_byte_strobe_out,
    input logic                lower_byte_strobe_oe,
    input logic                upper_byte_strobe_out,
    input logic                upper_byte_strobe_oe,
    input logic                core_ready
);
    // --------------------------------
    // command decode, lock counter, burst length copy
    // --------------------------------
    logic       take;
    logic       rd_c;
    logic       wr_c;
    logic       lm_c;
    logic [2:0] code;
    logic [7:0] cnt_d;
    logic [7:0] cnt_q;
    logic       bl8_d;
    logic       bl8_q;

    // a load during a read burst is not seen here; the controller may not issue one
    assign code = {cmd.ras_n, cmd.cas_n, cmd.we_n};
    assign take = cmd.cke && !cmd.cs_n;
    assign rd_c = take && code == ddrm_pkg::CMD_RD;
    assign wr_c = take && code == ddrm_pkg::CMD_WR;
    assign lm_c = take && code == ddrm_pkg::CMD_LM && cmd.ba == ddrm_pkg::SEL_MODE && !dq_oe;

    // next values: counter saturates so it never wraps into a false refusal
    always_comb begin
        cnt_d = cnt_q;
        bl8_d = bl8_q;
        if (lm_c && cmd.addr[8]) begin
            cnt_d = 8'h00;
        end else if (cnt_q != 8'hFF) begin
            cnt_d = cnt_q + 8'h01;
        end
        if (lm_c) begin
            bl8_d = cmd.addr[2:0] == ddrm_pkg::BL_EIGHT;
        end
    end

    // registers
    always_ff @(posedge link_clk) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            bl8_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            bl8_q <= bl8_d;
        end
    end

    // --------------------------------
    // properties
    // --------------------------------
    chk_read_start: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(dq_oe) |-> $past(rd_c, 2)) else $error("read data without a read command");
    chk_four_halves: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(dq_oe) |-> dq_oe [*2]) else $error("read burst shorter than two cycles");
    chk_eight_span: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(dq_oe) && bl8_q |-> dq_oe [*4]) else $error("burst of eight cut short");
    chk_dll_wait: assert property (@(posedge link_clk) disable iff (!rst_n)
        rd_c && !dq_oe && cnt_q < 8'hC7 |-> ##2 !dq_oe) else $error("read before dll lock");
    chk_write_quiet: assert property (@(posedge link_clk) disable iff (!rst_n)
        wr_c && !dq_oe && !$past(rd_c) |-> ##2 !dq_oe) else $error("data driven on a write");
    chk_strobe_en: assert property (@(posedge link_clk) disable iff (!rst_n)
        lower_byte_strobe_oe == dq_oe && upper_byte_strobe_oe == dq_oe)
        else $error("strobe enable differs from data enable");
    chk_strobe_high: assert property (@(negedge link_clk) disable iff (!rst_n)
        lower_byte_strobe_out == dq_oe && upper_byte_strobe_out == dq_oe)
        else $error("strobe not high in first half");
    chk_strobe_low: assert property (@(posedge link_clk) disable iff (!rst_n)
        !lower_byte_strobe_out && !upper_byte_strobe_out) else $error("strobe high in second half");
    chk_ready_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> !core_ready [*8]) else $error("ready right after reset");

endmodule : ddrm_core_assertions

bind ddrm_core ddrm_core_assertions i_ddrm_core_assertions (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .cmd(cmd), .dq_oe(dq_oe),
    .lower_byte_strobe_out(lower_byte_strobe_out), .lower_byte_strobe_oe(lower_byte_strobe_oe),
    .upper_byte_strobe_out(upper_byte_strobe_out), .upper_byte_strobe_oe(upper_byte_strobe_oe),
    .core_ready(core_ready)
);

// ==== ddrm_ctrl_model.sv ====
/*
 * Memory controller model: commands on rising link edges, write beats
 * on both edges, centred write strobe, toggling data when idle.
 * Assumes the bench calls op, gap and wr and raises ck once.
 */
`timescale 1ns/1ps

module ddrm_ctrl_model (
    input  logic                link_clk,
    output ddrm_pkg::ddrm_cmd_t cmd,
    output logic [15:0]         dq_in,
    output logic                lower_byte_write_mask,
    output logic                upper_byte_write_mask,
    output logic                lower_byte_strobe_in,
    output logic                upper_byte_strobe_in
);
    int   n_op = 0;
    logic ck   = 1'b0;
    logic busy = 1'b0;
    logic dqs  = 1'b0;

    // idle values at time zero
    initial begin
        cmd   = {1'b0, 1'b1, 3'h7, 3'h0, 14'h0000};
        dq_in = 16'h0000;
    end

    // --------------------------------
    // command and write tasks
    // --------------------------------
    // one command per rising edge; ck never falls once raised
    task automatic op(input logic [2:0] c, input logic [2:0] ba, input logic [13:0] a);
        @(posedge link_clk);
        cmd  <= {ck, 1'b0, c, ba, a};
        n_op += 1;
    endtask : op

    // waiting intervals carry only nop
    task automatic gap(input int n);
        repeat (n) op(ddrm_pkg::CMD_NOP, 3'h0, 14'h0000);
    endtask : gap

    // beats go out on alternate edges, the first after the next rise
    task automatic wr(input logic [13:0] a, input logic [15:0] w [8], input int n);
        op(ddrm_pkg::CMD_WR, 3'h0, a);
        busy = 1'b1;
        for (int i = 0; i < n; i++) begin
            if (i % 2 == 0) begin
                gap(1);
            end else begin
                @(negedge link_clk);
            end
            dq_in <= w[i];
        end
        gap(1);
        busy = 1'b0;
    endtask : wr

    // released data line toggles so a stale word never looks valid
    always @(link_clk) begin
        if (!busy) begin
            dq_in <= ~dq_in;
        end
    end

    // strobe edges land mid-eye, a quarter cycle after the data
    always @(link_clk) begin
        dqs <= #40 link_clk;
    end

    assign lower_byte_strobe_in  = busy & dqs;
    assign upper_byte_strobe_in  = busy & dqs;
    assign lower_byte_write_mask = 1'b0;
    assign upper_byte_write_mask = 1'b0;

endmodule : ddrm_ctrl_model

// ==== ddrm_core_test.sv ====
/*
 * Testbench: power-up sequence, lock wait, burst orders and lengths,
 * burst cut, auto precharge; reads checked against a column model.
 * Assumes ddrm_pkg, ddrm_core, the checker and the controller model.
 */
`timescale 1ns/1ps

module ddrm_core_test;
    logic                sys_clk  = 1'b0;
    logic                link_clk = 1'b0;
    logic                rst_n    = 1'b0;
    ddrm_pkg::ddrm_cmd_t cmd;
    logic [15:0]         dq_in;
    logic [15:0]         dq_out;
    logic                dq_oe, ls_o, ls_e, us_o, us_e, ls_i, us_i, lm, um, core_ready;
    int                  n_mismatch   = 0;
    int                  total_checks = 0;
    int                  t0;
    logic [15:0]         exp_q [$];
    logic [15:0]         mem [32];
    logic [7:0]          lf = 8'h5C;

    ddrm_core #(.ROW_KEEP(2), .COL_BITS(5)) i_ddrm_core (
        .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .cmd(cmd), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .lower_byte_write_mask(lm),
        .upper_byte_write_mask(um), .lower_byte_strobe_in(ls_i),
        .lower_byte_strobe_out(ls_o), .lower_byte_strobe_oe(ls_e),
        .upper_byte_strobe_in(us_i), .upper_byte_strobe_out(us_o),
        .upper_byte_strobe_oe(us_e), .core_ready(core_ready));

    ddrm_ctrl_model i_ddrm_ctrl_model (
        .link_clk(link_clk), .cmd(cmd), .dq_in(dq_in), .lower_byte_write_mask(lm),
        .upper_byte_write_mask(um), .lower_byte_strobe_in(ls_i),
        .upper_byte_strobe_in(us_i));

    // clocks: link phase unrelated to the system clock
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end

    // --------------------------------
    // helpers
    // --------------------------------
    function automatic logic [15:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return {lf, ~lf};
    endfunction : rnd

    // column of beat i: sequential wraps per half, interleaved xors
    function automatic logic [4:0] at(input logic [4:0] c, input int i, input logic il);
        logic [2:0] k;
        k = 3'(i);
        if (il) begin
            return {c[4:3], c[2:0] ^ k};
        end
        return {c[4:3], c[2] ^ k[2], c[1:0] + k[1:0]};
    endfunction : at

    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        total_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check

    task automatic issue(input logic [2:0] c, input logic [2:0] ba, input logic [13:0] a);
        i_ddrm_ctrl_model.op(c, ba, a);
    endtask : issue

    task automatic idle(input int n);
        i_ddrm_ctrl_model.gap(n);
    endtask : idle

    // load then the mode-register delay
    task automatic load(input logic [2:0] ba, input logic [13:0] a);
        issue(ddrm_pkg::CMD_LM, ba, a);
        idle(2);
    endtask : load

    // banks closed around a mode change, then the row reopened
    task automatic setmode(input logic [13:0] m);
        issue(ddrm_pkg::CMD_PRE, 3'h0, 14'h0400);
        idle(1);
        load(ddrm_pkg::SEL_MODE, m);
        issue(ddrm_pkg::CMD_ACT, 3'h0, 14'h0000);
        idle(1);
    endtask : setmode

    task automatic wburst(input logic [4:0] c, input int n, input logic il);
        logic [15:0] w [8];
        for (int i = 0; i < n; i++) begin
            w[i]            = rnd();
            mem[at(c, i, il)] = w[i];
        end
        i_ddrm_ctrl_model.wr({9'h000, c}, w, n);
    endtask : wburst

    // n words noted for the monitor; n = 0 means the read must be refused
    task automatic rburst(input logic [4:0] c, input int n, input logic il, input logic ap);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(mem[at(c, i, il)]);
        end
        issue(ddrm_pkg::CMD_RD, 3'h0, {3'h0, ap, 5'h00, c});
    endtask : rburst

    // monitor: every half-cycle beat against the oldest note
    always @(link_clk) begin
        #20;
        if (dq_oe === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(16'(dq_oe), 16'h0000, "unexpected beat");
            end else begin
                check(dq_out, exp_q.pop_front(), "beat");
            end
            check(16'(ls_o & us_o), 16'(link_clk), "strobe");
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // watchdog: whole run is about 1600 link cycles, allow over twice that
    initial begin
        #600000;
        n_mismatch++;
        stop_test();
    end

    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        repeat (16) @(posedge link_clk);
        check(16'(dq_oe), 16'h0000, "oe in reset");
        check(16'(core_ready), 16'h0000, "ready in reset");
        @(posedge sys_clk);
        rst_n <= 1'b1;
        idle(1250);
        i_ddrm_ctrl_model.ck = 1'b1;
        idle(3);
        issue(ddrm_pkg::CMD_PRE, 3'h0, 14'h0400);
        load(ddrm_pkg::SEL_EXT2, 14'h0080);
        load(ddrm_pkg::SEL_EXT3, 14'h0000);
        load(ddrm_pkg::SEL_EXT1, 14'h0000);
        issue(ddrm_pkg::CMD_LM, ddrm_pkg::SEL_MODE, 14'h0100);
        t0 = i_ddrm_ctrl_model.n_op;
        idle(2);
        issue(ddrm_pkg::CMD_PRE, 3'h0, 14'h0400);
        issue(ddrm_pkg::CMD_REF, 3'h0, 14'h0000);
        issue(ddrm_pkg::CMD_REF, 3'h0, 14'h0000);
        load(ddrm_pkg::SEL_MODE, 14'h0002);
        load(ddrm_pkg::SEL_EXT1, 14'h0380);
        load(ddrm_pkg::SEL_EXT1, 14'h0000);
        issue(ddrm_pkg::CMD_ACT, 3'h0, 14'h0000);
        idle(2);
        rburst(5'h00, 0, 1'b0, 1'b0);
        idle(4);
        check(16'(core_ready), 16'h0000, "ready early");
        idle(t0 + 198 - i_ddrm_ctrl_model.n_op);
        issue(ddrm_pkg::CMD_WR, 3'h0, 14'h0008);
        wburst(5'h01, 4, 1'b0);
        idle(6);
        check(16'(core_ready), 16'h0001, "ready after lock");
        for (int s = 0; s < 4; s++) begin
            rburst(5'(s), 4, 1'b0, 1'b0);
            idle(2);
        end
        idle(3);
        setmode(14'h0003);
        wburst(5'h0D, 8, 1'b0);
        idle(2);
        rburst(5'h09, 4, 1'b0, 1'b0);
        idle(1);
        rburst(5'h0E, 8, 1'b0, 1'b0);
        idle(8);
        setmode(14'h000B);
        rburst(5'h0D, 8, 1'b1, 1'b0);
        idle(8);
        setmode(14'h000A);
        rburst(5'h03, 4, 1'b1, 1'b1);
        idle(6);
        rburst(5'h00, 0, 1'b0, 1'b0);
        idle(6);
        check(16'(exp_q.size()), 16'h0000, "missing beats");
        stop_test();
    end

endmodule : ddrm_core_test
